//--- design/pps_pkg.sv
package pps_pkg;

    // Port widths
    localparam int HC_W     = 4;
    localparam int PORT_W   = 8;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;

    // Register offsets
    localparam logic [3:0] OFS_HC_DATA   = 4'h0;
    localparam logic [3:0] OFS_HC_CTRL   = 4'h1;
    localparam logic [3:0] OFS_SEGA_DATA = 4'h2;
    localparam logic [3:0] OFS_SEGA_LCD  = 4'h3;
    localparam logic [3:0] OFS_SEGB_DATA = 4'h4;
    localparam logic [3:0] OFS_SEGB_LCD  = 4'h5;
    localparam logic [3:0] OFS_SER_DATA  = 4'h6;
    localparam logic [3:0] OFS_SER_LCD   = 4'h7;
    localparam logic [3:0] OFS_AN_DATA   = 4'h8;
    localparam logic [3:0] OFS_AN_DIR    = 4'h9;

    // Reset values: latches released high, every alternate select cleared
    localparam logic [3:0] RST_HC_LATCH  = 4'hF;
    localparam logic [3:0] RST_HC_CTRL   = 4'h0;
    localparam logic [7:0] RST_LATCH     = 8'hFF;
    localparam logic [7:0] RST_LCD_SEL   = 8'h00;
    localparam logic [7:0] RST_AN_DIR    = 8'h00;
    localparam logic [7:0] RST_RDATA     = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int RST_OUT_NS     = 2000;
    localparam int RST_OUT_CYC    = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_SETTLE_CYC = 3;

    typedef enum logic [1:0] {
        PPS_RP_IDLE    = 2'b00,
        PPS_RP_DRIVE   = 2'b01,
        PPS_RP_RELEASE = 2'b11
    } pps_rp_state_t;

endpackage

//--- design/pps_rst_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pps_rst_if;
    logic wdt_req;
    logic trap_req;
    logic pin_level;
    logic drive_low;
    logic ext_reset;

    modport ctl
    (
        input  wdt_req,
        input  trap_req,
        input  pin_level,
        output drive_low,
        output ext_reset
    );
    modport core
    (
        output wdt_req,
        output trap_req,
        output pin_level,
        input  drive_low,
        input  ext_reset
    );
endinterface
`default_nettype wire

//--- design/pps_reset_pin.sv
`timescale 1ns/1ps
`default_nettype none
module pps_reset_pin
#(
    parameter int HOLD_CYCLES = pps_pkg::RST_OUT_CYC
)
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    pps_rst_if.ctl    rp
);
    localparam int CW = $clog2(HOLD_CYCLES + pps_pkg::RST_SETTLE_CYC + 1);

    if (HOLD_CYCLES < 1)
    begin : g_bad_hold
        $error("HOLD_CYCLES must be at least 1");
    end

    pps_pkg::pps_rp_state_t state;
    pps_pkg::pps_rp_state_t next_state;
    logic [CW-1:0]          cnt;
    logic [CW-1:0]          next_cnt;

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            pps_pkg::PPS_RP_IDLE:
            begin
                if (rp.wdt_req || rp.trap_req)
                begin
                    next_state = pps_pkg::PPS_RP_DRIVE;
                    next_cnt   = CW'(HOLD_CYCLES - 1);
                end
            end
            pps_pkg::PPS_RP_DRIVE:
            begin
                if (cnt == '0)
                begin
                    next_state = pps_pkg::PPS_RP_RELEASE;
                    next_cnt   = CW'(pps_pkg::RST_SETTLE_CYC - 1);
                end
                else
                begin
                    next_cnt = cnt - CW'(1);
                end
            end
            pps_pkg::PPS_RP_RELEASE:
            begin
                // Mask our own low level while it climbs back through the synchroniser
                if (cnt == '0)
                begin
                    next_state = pps_pkg::PPS_RP_IDLE;
                end
                else
                begin
                    next_cnt = cnt - CW'(1);
                end
            end
            default:
            begin
                next_state = pps_pkg::PPS_RP_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= pps_pkg::PPS_RP_IDLE;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign rp.drive_low = (state == pps_pkg::PPS_RP_DRIVE);
    assign rp.ext_reset = (state == pps_pkg::PPS_RP_IDLE) && !rp.pin_level;

    // Length of the current low drive, for the check below
    logic [CW-1:0] drive_len;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_len <= '0;
        end
        else if (rp.drive_low)
        begin
            drive_len <= drive_len + CW'(1);
        end
        else
        begin
            drive_len <= '0;
        end
    end

    a_drive_on_request: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (state == pps_pkg::PPS_RP_IDLE && (rp.wdt_req || rp.trap_req)) |=> rp.drive_low)
        else $error("Reset pin not driven after internal reset request");

    a_drive_length: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(rp.drive_low) |-> (drive_len == CW'(HOLD_CYCLES)))
        else $error("Reset pin low drive has wrong length");

    a_no_self_echo: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(rp.drive_low) |-> !rp.ext_reset [*3])
        else $error("Own reset drive seen as external reset");
endmodule
`default_nettype wire

//--- design/pps_port_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A first segment-port pin drives its LCD segment instead of port data while its LCD select bit is one.
// - A second segment-port pin likewise drives its LCD segment while its LCD select bit is one.
// - Each analog-port pin has its own direction bit that alone decides whether it is driven.
// - The reset pin takes external reset in and is pulled low on a watchdog or address-trap reset.
module pps_port_pin_function_select
#(
    parameter int RST_HOLD_CYCLES = pps_pkg::RST_OUT_CYC
)
(
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic [pps_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [pps_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [pps_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic [pps_pkg::HC_W-1:0]      hc_pin_in,
    output logic      [pps_pkg::HC_W-1:0]      hc_pin_out,
    output logic      [pps_pkg::HC_W-1:0]      hc_pin_oe,
    input  wire logic [pps_pkg::HC_W-1:0]      hc_periph_out,
    output logic      [pps_pkg::HC_W-1:0]      hc_periph_in,
    input  wire logic [pps_pkg::PORT_W-1:0]    sega_pin_in,
    output logic      [pps_pkg::PORT_W-1:0]    sega_pin_out,
    output logic      [pps_pkg::PORT_W-1:0]    sega_pin_oe,
    input  wire logic [pps_pkg::PORT_W-1:0]    sega_lcd_segment_line,
    input  wire logic [pps_pkg::PORT_W-1:0]    segb_pin_in,
    output logic      [pps_pkg::PORT_W-1:0]    segb_pin_out,
    output logic      [pps_pkg::PORT_W-1:0]    segb_pin_oe,
    input  wire logic [pps_pkg::PORT_W-1:0]    segb_lcd_segment_line,
    input  wire logic [pps_pkg::PORT_W-1:0]    ser_pin_in,
    output logic      [pps_pkg::PORT_W-1:0]    ser_pin_out,
    output logic      [pps_pkg::PORT_W-1:0]    ser_pin_oe,
    input  wire logic [pps_pkg::PORT_W-1:0]    ser_lcd_segment_line,
    input  wire logic [pps_pkg::PORT_W-1:0]    ser_periph_out,
    output logic      [pps_pkg::PORT_W-1:0]    ser_periph_in,
    input  wire logic [pps_pkg::PORT_W-1:0]    an_pin_in,
    output logic      [pps_pkg::PORT_W-1:0]    an_pin_out,
    output logic      [pps_pkg::PORT_W-1:0]    an_pin_oe,
    output logic      [pps_pkg::PORT_W-1:0]    an_digital_in,
    output logic      [pps_pkg::PORT_W-1:0]    an_analog_sel,
    input  wire logic                          rst_pin_in,
    output logic                               rst_pin_out,
    output logic                               rst_pin_oe,
    input  wire logic                          wdt_reset_req,
    input  wire logic                          trap_reset_req,
    output logic                               ext_reset_req
);
    localparam int HW = pps_pkg::HC_W;
    localparam int PW = pps_pkg::PORT_W;
    localparam int SW = HW + 4 * PW + 1;

    if (HW > pps_pkg::DATA_W || PW > pps_pkg::DATA_W)
    begin : g_bad_width
        $error("Port wider than the register data bus");
    end

    // Two-stage synchroniser for every pin input
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_a <= '1;
            sync_b <= '1;
        end
        else
        begin
            sync_a <= {rst_pin_in, an_pin_in, ser_pin_in, segb_pin_in, sega_pin_in, hc_pin_in};
            sync_b <= sync_a;
        end
    end

    logic [HW-1:0] hc_lvl;
    logic [PW-1:0] sega_lvl;
    logic [PW-1:0] segb_lvl;
    logic [PW-1:0] ser_lvl;
    logic [PW-1:0] an_lvl;
    logic          rst_lvl;
    assign {rst_lvl, an_lvl, ser_lvl, segb_lvl, sega_lvl, hc_lvl} = sync_b;

    pps_rst_if rst_bus ();

    // Register file
    logic [HW-1:0] hc_port_data_latch;
    logic [HW-1:0] hc_port_output_ctrl;
    logic [PW-1:0] sega_latch;
    logic [PW-1:0] seg_port_a_lcd_select;
    logic [PW-1:0] segb_latch;
    logic [PW-1:0] seg_port_b_lcd_select;
    logic [PW-1:0] ser_latch;
    logic [PW-1:0] seg_port_serial_lcd_select;
    logic [PW-1:0] an_latch;
    logic [PW-1:0] analog_port_direction_ctrl;
    logic [pps_pkg::DATA_W-1:0] next_rdata;
    logic [HW-1:0] next_hc_latch;
    logic [HW-1:0] next_hc_ctrl;
    logic [PW-1:0] next_sega_latch;
    logic [PW-1:0] next_sega_sel;
    logic [PW-1:0] next_segb_latch;
    logic [PW-1:0] next_segb_sel;
    logic [PW-1:0] next_ser_latch;
    logic [PW-1:0] next_ser_sel;
    logic [PW-1:0] next_an_latch;
    logic [PW-1:0] next_an_dir;

    // Data offsets read back pin levels, control offsets read back the register
    function automatic logic [pps_pkg::DATA_W-1:0] read_mux(input logic [pps_pkg::ADDR_W-1:0] a);
        logic [pps_pkg::DATA_W-1:0] d;
        d = '0;
        case (a)
            pps_pkg::OFS_HC_DATA:   d[HW-1:0] = hc_lvl;
            pps_pkg::OFS_HC_CTRL:   d[HW-1:0] = hc_port_output_ctrl;
            pps_pkg::OFS_SEGA_DATA: d[PW-1:0] = sega_lvl;
            pps_pkg::OFS_SEGA_LCD:  d[PW-1:0] = seg_port_a_lcd_select;
            pps_pkg::OFS_SEGB_DATA: d[PW-1:0] = segb_lvl;
            pps_pkg::OFS_SEGB_LCD:  d[PW-1:0] = seg_port_b_lcd_select;
            pps_pkg::OFS_SER_DATA:  d[PW-1:0] = ser_lvl;
            pps_pkg::OFS_SER_LCD:   d[PW-1:0] = seg_port_serial_lcd_select;
            pps_pkg::OFS_AN_DATA:   d[PW-1:0] = an_lvl;
            pps_pkg::OFS_AN_DIR:    d[PW-1:0] = analog_port_direction_ctrl;
            default:                d = '0;
        endcase
        return d;
    endfunction

    always_comb
    begin
        next_hc_latch   = hc_port_data_latch;
        next_hc_ctrl    = hc_port_output_ctrl;
        next_sega_latch = sega_latch;
        next_sega_sel   = seg_port_a_lcd_select;
        next_segb_latch = segb_latch;
        next_segb_sel   = seg_port_b_lcd_select;
        next_ser_latch  = ser_latch;
        next_ser_sel    = seg_port_serial_lcd_select;
        next_an_latch   = an_latch;
        next_an_dir     = analog_port_direction_ctrl;
        next_rdata      = reg_rd ? read_mux(reg_addr) : pps_pkg::RST_RDATA;
        if (reg_wr)
        begin
            case (reg_addr)
                pps_pkg::OFS_HC_DATA:   next_hc_latch   = reg_wdata[HW-1:0];
                pps_pkg::OFS_HC_CTRL:   next_hc_ctrl    = reg_wdata[HW-1:0];
                pps_pkg::OFS_SEGA_DATA: next_sega_latch = reg_wdata[PW-1:0];
                pps_pkg::OFS_SEGA_LCD:  next_sega_sel   = reg_wdata[PW-1:0];
                pps_pkg::OFS_SEGB_DATA: next_segb_latch = reg_wdata[PW-1:0];
                pps_pkg::OFS_SEGB_LCD:  next_segb_sel   = reg_wdata[PW-1:0];
                pps_pkg::OFS_SER_DATA:  next_ser_latch  = reg_wdata[PW-1:0];
                pps_pkg::OFS_SER_LCD:   next_ser_sel    = reg_wdata[PW-1:0];
                pps_pkg::OFS_AN_DATA:   next_an_latch   = reg_wdata[PW-1:0];
                pps_pkg::OFS_AN_DIR:    next_an_dir     = reg_wdata[PW-1:0];
                default:                next_rdata      = next_rdata;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Every select clear, every latch released
            hc_port_data_latch         <= pps_pkg::RST_HC_LATCH;
            hc_port_output_ctrl        <= pps_pkg::RST_HC_CTRL;
            sega_latch                 <= pps_pkg::RST_LATCH;
            seg_port_a_lcd_select      <= pps_pkg::RST_LCD_SEL;
            segb_latch                 <= pps_pkg::RST_LATCH;
            seg_port_b_lcd_select      <= pps_pkg::RST_LCD_SEL;
            ser_latch                  <= pps_pkg::RST_LATCH;
            seg_port_serial_lcd_select <= pps_pkg::RST_LCD_SEL;
            an_latch                   <= pps_pkg::RST_LATCH;
            analog_port_direction_ctrl <= pps_pkg::RST_AN_DIR;
            reg_rdata                  <= pps_pkg::RST_RDATA;
        end
        else
        begin
            hc_port_data_latch         <= next_hc_latch;
            hc_port_output_ctrl        <= next_hc_ctrl;
            sega_latch                 <= next_sega_latch;
            seg_port_a_lcd_select      <= next_sega_sel;
            segb_latch                 <= next_segb_latch;
            seg_port_b_lcd_select      <= next_segb_sel;
            ser_latch                  <= next_ser_latch;
            seg_port_serial_lcd_select <= next_ser_sel;
            an_latch                   <= next_an_latch;
            analog_port_direction_ctrl <= next_an_dir;
            reg_rdata                  <= next_rdata;
        end
    end

    // Pin drive; registered so pins never glitch on select changes
    logic [HW-1:0] next_hc_out;
    logic [HW-1:0] next_hc_oe;
    logic [PW-1:0] next_sega_out;
    logic [PW-1:0] next_sega_oe;
    logic [PW-1:0] next_segb_out;
    logic [PW-1:0] next_segb_oe;
    logic [PW-1:0] next_ser_out;
    logic [PW-1:0] next_ser_oe;
    logic          next_rst_oe;
    logic [HW-1:0] hc_val;
    logic [PW-1:0] ser_val;

    always_comb
    begin
        // Peripheral outputs idle high, so a zero latch would mask them
        hc_val        = hc_port_data_latch & hc_periph_out;
        // Control one drives both levels; control zero sinks only
        next_hc_out   = hc_val;
        next_hc_oe    = hc_port_output_ctrl | ~hc_val;
        // Segment line replaces port data per bit
        next_sega_out = (seg_port_a_lcd_select & sega_lcd_segment_line)
                      | (~seg_port_a_lcd_select & sega_latch);
        next_sega_oe  = seg_port_a_lcd_select | ~sega_latch;
        next_segb_out = (seg_port_b_lcd_select & segb_lcd_segment_line)
                      | (~seg_port_b_lcd_select & segb_latch);
        next_segb_oe  = seg_port_b_lcd_select | ~segb_latch;
        ser_val       = ser_latch & ser_periph_out;
        next_ser_out  = (seg_port_serial_lcd_select & ser_lcd_segment_line)
                      | (~seg_port_serial_lcd_select & ser_val);
        next_ser_oe   = seg_port_serial_lcd_select | ~ser_val;
        next_rst_oe   = rst_bus.drive_low;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hc_pin_out   <= '1;
            hc_pin_oe    <= '0;
            sega_pin_out <= '1;
            sega_pin_oe  <= '0;
            segb_pin_out <= '1;
            segb_pin_oe  <= '0;
            ser_pin_out  <= '1;
            ser_pin_oe   <= '0;
            rst_pin_oe   <= 1'b0;
        end
        else
        begin
            hc_pin_out   <= next_hc_out;
            hc_pin_oe    <= next_hc_oe;
            sega_pin_out <= next_sega_out;
            sega_pin_oe  <= next_sega_oe;
            segb_pin_out <= next_segb_out;
            segb_pin_oe  <= next_segb_oe;
            ser_pin_out  <= next_ser_out;
            ser_pin_oe   <= next_ser_oe;
            rst_pin_oe   <= next_rst_oe;
        end
    end

    // Analog port: direction bit alone gates the driver
    assign an_pin_out    = an_latch;
    assign an_pin_oe     = analog_port_direction_ctrl;
    // Latch zero with direction zero routes the pin to the converter
    assign an_analog_sel = ~an_latch & ~analog_port_direction_ctrl;
    // Digital receivers read one while in analog use, avoiding false wake-ups
    assign an_digital_in = an_lvl | an_analog_sel;
    assign hc_periph_in  = hc_lvl;
    assign ser_periph_in = ser_lvl;
    assign rst_pin_out   = 1'b0;

    assign rst_bus.wdt_req   = wdt_reset_req;
    assign rst_bus.trap_req  = trap_reset_req;
    assign rst_bus.pin_level = rst_lvl;
    assign ext_reset_req     = rst_bus.ext_reset;

    pps_reset_pin
    #(
        .HOLD_CYCLES (RST_HOLD_CYCLES)
    )
    u_reset_pin
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .rp       (rst_bus)
    );

    logic first_cycle;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first_cycle <= 1'b1;
        end
        else
        begin
            first_cycle <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_sega_lcd_route: assert property (
        (seg_port_a_lcd_select == '1) |=> (sega_pin_out == $past(sega_lcd_segment_line)) && (sega_pin_oe == '1))
        else $error("First segment port not driving segment lines");

    a_segb_port_route: assert property (
        (seg_port_b_lcd_select == '0) |=> (segb_pin_out == $past(segb_latch)))
        else $error("Second segment port not driving port data");

    a_segb_lcd_write: assert property (
        (reg_wr && reg_addr == pps_pkg::OFS_SEGB_LCD && reg_wdata == '1)
        |=> ##1 (segb_pin_out == $past(segb_lcd_segment_line)))
        else $error("Second segment port select write not effective");

    a_an_dir_write: assert property (
        (reg_wr && reg_addr == pps_pkg::OFS_AN_DIR) |=> (an_pin_oe == $past(reg_wdata)))
        else $error("Analog port direction not taken per bit");

    a_reset_defaults: assert property (
        first_cycle |-> (seg_port_a_lcd_select == '0 && seg_port_b_lcd_select == '0
                         && seg_port_serial_lcd_select == '0 && an_pin_oe == '0
                         && hc_port_output_ctrl == '0))
        else $error("Select bits not clear after reset");

    a_rst_pin_drive: assert property (
        $rose(rst_bus.drive_low) |=> rst_pin_oe && !ext_reset_req)
        else $error("Reset pin not pulled low");

    a_rdata_only_after: assert property (
        !$past(reg_rd) |-> (reg_rdata == '0))
        else $error("Read data present without a read");
endmodule
`default_nettype wire

//--- verif/pps_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pps_partner
(
    input  wire logic       core_clk,
    input  wire logic [3:0] hc_pin_out,
    input  wire logic [3:0] hc_pin_oe,
    output logic      [3:0] hc_pin_in,
    output logic      [3:0] hc_periph_out,
    input  wire logic [7:0] sega_pin_out,
    input  wire logic [7:0] sega_pin_oe,
    output logic      [7:0] sega_pin_in,
    input  wire logic [7:0] segb_pin_out,
    input  wire logic [7:0] segb_pin_oe,
    output logic      [7:0] segb_pin_in,
    input  wire logic [7:0] ser_pin_out,
    input  wire logic [7:0] ser_pin_oe,
    output logic      [7:0] ser_pin_in,
    input  wire logic [7:0] an_pin_out,
    input  wire logic [7:0] an_pin_oe,
    output logic      [7:0] an_pin_in,
    input  wire logic       rst_pin_out,
    input  wire logic       rst_pin_oe,
    output logic            rst_pin_in,
    input  wire logic       board_rst_low
);
    // Board pull-ups: an undriven pin reads high
    assign hc_pin_in = (hc_pin_oe & hc_pin_out) | ~hc_pin_oe;
    assign sega_pin_in = (sega_pin_oe & sega_pin_out) | ~sega_pin_oe;
    assign segb_pin_in = (segb_pin_oe & segb_pin_out) | ~segb_pin_oe;
    assign ser_pin_in = (ser_pin_oe & ser_pin_out) | ~ser_pin_oe;
    assign an_pin_in = (an_pin_oe & an_pin_out) | ~an_pin_oe;
    // Timer output pattern so the latch gating shows bit by bit
    assign hc_periph_out = 4'hA;
    // Reset wire is open-drain: either party pulls it low
    assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | board_rst_low);
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int H = 4;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wdt = 1'b0;
    logic trap = 1'b0;
    logic brd_low = 1'b0;
    logic [7:0] se_po = 8'hFF;
    logic [7:0] rdata, sa_o, sa_e, sa_i, sb_o, sb_e, sb_i, se_o, se_e, se_i, se_p;
    logic [7:0] an_o, an_e, an_i, an_d, an_s;
    logic [3:0] hc_i, hc_o, hc_e, hc_po, hc_pi;
    logic rp_i, rp_o, rp_e, ext_rq;
    int failures = 0;
    int n_compared = 0;
    int n;
    initial forever #2.5 core_clk = ~core_clk;
    pps_port_pin_function_select #(.RST_HOLD_CYCLES(H)) u_dut
    (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .hc_pin_in(hc_i),
        .hc_pin_out(hc_o), .hc_pin_oe(hc_e), .hc_periph_out(hc_po), .hc_periph_in(hc_pi),
        .sega_pin_in(sa_i), .sega_pin_out(sa_o), .sega_pin_oe(sa_e),
        .sega_lcd_segment_line(8'h5A), .segb_pin_in(sb_i), .segb_pin_out(sb_o),
        .segb_pin_oe(sb_e), .segb_lcd_segment_line(8'hC3), .ser_pin_in(se_i),
        .ser_pin_out(se_o), .ser_pin_oe(se_e), .ser_lcd_segment_line(8'h96),
        .ser_periph_out(se_po), .ser_periph_in(se_p), .an_pin_in(an_i), .an_pin_out(an_o),
        .an_pin_oe(an_e), .an_digital_in(an_d), .an_analog_sel(an_s), .rst_pin_in(rp_i),
        .rst_pin_out(rp_o), .rst_pin_oe(rp_e), .wdt_reset_req(wdt),
        .trap_reset_req(trap), .ext_reset_req(ext_rq)
    );
    pps_partner u_far
    (
        .core_clk(core_clk), .hc_pin_out(hc_o), .hc_pin_oe(hc_e), .hc_pin_in(hc_i),
        .hc_periph_out(hc_po), .sega_pin_out(sa_o), .sega_pin_oe(sa_e), .sega_pin_in(sa_i),
        .segb_pin_out(sb_o), .segb_pin_oe(sb_e), .segb_pin_in(sb_i), .ser_pin_out(se_o),
        .ser_pin_oe(se_e), .ser_pin_in(se_i), .an_pin_out(an_o), .an_pin_oe(an_e),
        .an_pin_in(an_i), .rst_pin_out(rp_o), .rst_pin_oe(rp_e), .rst_pin_in(rp_i),
        .board_rst_low(brd_low)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset;
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h9, 8'h00);
        rd(4'hA, 8'h00);
        chk(sa_e, 8'h00);
        chk(an_e, 8'h00);
    endtask
    task automatic t_lcd;
        wr(4'h3, 8'hFF);
        wr(4'h5, 8'hF0);
        settle(2);
        chk(sa_o, 8'h5A);
        chk(sa_e, 8'hFF);
        chk(sb_o, 8'hCF);
        chk(sb_e, 8'hF0);
        wr(4'h5, 8'hFF);
        settle(2);
        chk(sb_o, 8'hC3);
        chk(sb_e, 8'hFF);
    endtask
    task automatic t_serial;
        wr(4'h6, 8'hFF);
        wr(4'h7, 8'h0F);
        settle(3);
        chk(se_o, 8'hF6);
        wr(4'h7, 8'h00);
        settle(4);
        chk(se_e, 8'h00);
        chk(se_p, 8'hFF);
        @(posedge core_clk);
        se_po <= 8'h3C;
        settle(2);
        chk(se_o, 8'h3C);
        chk(se_e, 8'hC3);
        settle(2);
        chk(se_p, 8'h3C);
    endtask
    task automatic t_analog;
        wr(4'h8, 8'hF0);
        wr(4'h9, 8'h0C);
        settle(3);
        chk(an_e, 8'h0C);
        chk(an_o, 8'hF0);
        chk(an_s, 8'h03);
        chk(an_d, 8'hF3);
    endtask
    task automatic t_hc;
        wr(4'h0, 8'h0F);
        wr(4'h1, 8'h0F);
        settle(2);
        chk({4'h0, hc_o}, 8'h0A);
        chk({4'h0, hc_e}, 8'h0F);
        wr(4'h1, 8'h00);
        settle(3);
        chk({4'h0, hc_e}, 8'h05);
        rd(4'h0, 8'h0A);
        chk({4'h0, hc_pi}, 8'h0A);
        wr(4'h0, 8'h07);
        settle(2);
        chk({4'h0, hc_o}, 8'h02);
        chk({4'h0, hc_e}, 8'h0D);
    endtask
    // Wire levels only; the hold length is the point of the check
    task automatic t_rst(input logic w);
        @(posedge core_clk);
        wdt <= w;
        trap <= ~w;
        @(posedge core_clk);
        wdt <= 1'b0;
        trap <= 1'b0;
        n = 0;
        while (rp_e !== 1'b1 && n < 10)
        begin
            n++;
            settle(1);
        end
        n = 0;
        while (rp_e === 1'b1 && n < 20)
        begin
            chk({7'h0, ext_rq}, 8'h00);
            n++;
            settle(1);
        end
        chk(8'(n), 8'(H));
        chk({7'h0, rp_o}, 8'h00);
        settle(6);
    endtask
    task automatic results;
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #20000;
        failures++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_lcd();
        t_serial();
        t_analog();
        t_hc();
        t_rst(1'b1);
        t_rst(1'b0);
        @(posedge core_clk);
        brd_low <= 1'b1;
        settle(3);
        chk({7'h0, ext_rq}, 8'h01);
        results();
    end
endmodule
`default_nettype wire
